// file: common/rbc_pkg.sv
// Package for the remote bus interface configuration block
// Assumes a 10 MHz system clock and static jumper inputs
package rbc_pkg;
	localparam int unsigned CLK_SYS_HZ      = 10_000_000;
	// Control-logic clock rates
	localparam int unsigned RATE_SLOW_HZ    = 2_500_000;
	localparam int unsigned RATE_MID_HZ     = 5_000_000;
	localparam int unsigned RATE_FAST_HZ    = 10_000_000;
	localparam logic [3:0] DIV_SLOW         = 4'(CLK_SYS_HZ / RATE_SLOW_HZ);
	localparam logic [3:0] DIV_MID          = 4'(CLK_SYS_HZ / RATE_MID_HZ);
	localparam logic [3:0] DIV_FAST         = 4'(CLK_SYS_HZ / RATE_FAST_HZ);
	// Access cycle limits in ns
	localparam int unsigned CYC_NORMAL_NS   = 26_500;
	localparam int unsigned CYC_PROLONG_NS  = 38_000;
	localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_SYS_HZ;
	localparam logic [9:0] CYC_NORMAL_CNT   = 10'(CYC_NORMAL_NS / CLK_PERIOD_NS);
	localparam logic [9:0] CYC_PROLONG_CNT  = 10'(CYC_PROLONG_NS / CLK_PERIOD_NS);
	// Strobe phase length in control ticks
	localparam logic [7:0] STROBE_NORMAL    = 8'h04;
	localparam logic [7:0] STROBE_PROLONG   = 8'h08;
	// Flash generator half period in sys cycles
	localparam logic [22:0] FLASH_HALF_CNT  = 23'h0F_4240;
	// Register map
	localparam logic [3:0] ADDR_CFG         = 4'h0;
	localparam logic [3:0] ADDR_STATUS      = 4'h1;
	localparam logic [3:0] ADDR_IRQ_STAT    = 4'h2;
	localparam logic [3:0] ADDR_IRQ_CLR     = 4'h3;
	localparam logic [3:0] ADDR_IRQ_EN      = 4'h4;
	localparam logic [3:0] ADDR_CFG_ERR     = 4'h5;
	// Interrupt bit positions
	localparam int unsigned IRQ_DONE_BIT    = 0;
	localparam int unsigned IRQ_DBL_BIT     = 1;
	localparam int unsigned IRQ_TMO_BIT     = 2;
	localparam int unsigned IRQ_BLK_BIT     = 3;
	localparam logic [3:0] IRQ_EN_RST       = 4'h0;
	// Slot base values
	localparam logic [5:0] SLOT_BASE_0      = 6'h00;
	localparam logic [5:0] SLOT_BASE_1      = 6'h10;
	localparam logic [5:0] SLOT_BASE_2      = 6'h20;
	localparam logic [5:0] SLOT_BASE_3      = 6'h30;
	localparam logic [5:0] SLOT_SPAN        = 6'h0D;
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_STROBE = 4'b0010,
		ST_WAIT   = 4'b0100,
		ST_DONE   = 4'b1000
	} rbc_state_type;
endpackage

// file: src/rbc_flash.sv
// On-board flash generator for the common error indicator
// Assumes clk_sys_i at the package rate
`timescale 1ns/10ps
`default_nettype none
module rbc_flash (
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	output logic      flash_o
);
	logic [22:0] cnt_r;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r   <= 23'h00_0000;
			flash_o <= 1'b0;
		end else if (cnt_r == rbc_pkg::FLASH_HALF_CNT - 23'h00_0001) begin
			cnt_r   <= 23'h00_0000;
			flash_o <= ~flash_o;
		end else begin
			cnt_r <= cnt_r + 23'h00_0001;
		end
	end
endmodule
`default_nettype wire

// file: src/rbc_core.sv
// Configuration-dependent control logic of the remote bus interface card
// Assumes jumper inputs are static and synchronous to clk_sys_i
//
// What this block does
// - Role jumper open extension, inserted basic
// - Host-family jumper matters only in extension role
// - Flash from on-board generator or external line
// - Control clock 2.5, 5 or 10 MHz
// - Last other-family extension forces ready low
// - Test jumper lets high test inhibit access
// - Lock jumper lets high lock block access
// - Delay jumper open lengthens access time
// - Detect double addressing between extension units
// - Access completes within 26.5 or 38 us
`timescale 1ns/10ps
`default_nettype none
module rbc_core (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        unit_role_select_i,
	input  wire logic        host_family_select_i,
	input  wire logic        flash_src_sel_i,
	input  wire logic [2:0]  clk_rate_sel_i,
	input  wire logic        last_unit_sel_i,
	input  wire logic        test_jmp_i,
	input  wire logic        lock_jmp_i,
	input  wire logic        delay_off_i,
	input  wire logic [1:0]  frame_addr_jmp_i,
	input  wire logic        external_flash_line_i,
	input  wire logic        test_line_i,
	input  wire logic        lock_line_i,
	input  wire logic        io_req_i,
	input  wire logic [5:0]  io_slot_i,
	input  wire logic        periph_ready_line_i,
	input  wire logic        io_acknowledge_line_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic [31:0]      reg_rdata_o,
	output logic             irq_o,
	output logic             ctl_tick_o,
	output logic             io_strobe_o,
	output logic             io_busy_o,
	output logic             io_done_o,
	output logic             io_timeout_o,
	output logic             dbl_addr_o,
	output logic             slot_hit_o,
	output logic             periph_ready_input_o,
	output logic             periph_ready_input_oe_o,
	output logic             err_flash_o,
	output logic             extension_unit_o,
	output logic             basic_unit_o,
	output logic             host_other_o,
	output logic [1:0]       slot_addr_bits_o,
	output logic             cfg_err_o
);
	// Sampled configuration
	logic        role_basic_r;
	logic        host_other_r;
	logic        flash_ext_r;
	logic [2:0]  rate_r;
	logic        last_unit_r;
	logic        test_en_r;
	logic        lock_en_r;
	logic        prolong_r;
	logic [1:0]  frame_r;
	logic        cfg_load_r;

	logic [3:0]  div_cnt_r;
	logic [3:0]  div_val;
	logic        tick;
	rbc_pkg::rbc_state_type state_r;
	rbc_pkg::rbc_state_type state_nxt;
	logic [7:0]  ph_cnt_r;
	logic [9:0]  cyc_cnt_r;
	logic [9:0]  cyc_lim;
	logic [7:0]  strobe_len;
	logic        inhibit;
	logic        ack_both;
	logic        done_ev;
	logic        tmo_ev;
	logic        dbl_ev;
	logic        blk_ev;
	logic [3:0]  irq_stat_r;
	logic [3:0]  irq_en_r;
	logic [3:0]  irq_set;
	logic [3:0]  irq_clr;
	logic        flash_int;
	logic [5:0]  slot_base;

	// Slot base from frame jumpers, inserted reads as one
	function automatic logic [5:0] slot_base_of(input logic [1:0] f);
		case (f)
			2'b11:   slot_base_of = rbc_pkg::SLOT_BASE_0;
			2'b10:   slot_base_of = rbc_pkg::SLOT_BASE_1;
			2'b01:   slot_base_of = rbc_pkg::SLOT_BASE_2;
			default: slot_base_of = rbc_pkg::SLOT_BASE_3;
		endcase
	endfunction

	// Clock divisor from the one-hot rate jumpers
	function automatic logic [3:0] div_of(input logic [2:0] r);
		case (r)
			3'b001:  div_of = rbc_pkg::DIV_SLOW;
			3'b010:  div_of = rbc_pkg::DIV_MID;
			3'b100:  div_of = rbc_pkg::DIV_FAST;
			default: div_of = rbc_pkg::DIV_SLOW;
		endcase
	endfunction

	// Capture jumpers in the first cycle after reset release
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_load_r   <= 1'b1;
			role_basic_r <= 1'b0;
			host_other_r <= 1'b0;
			flash_ext_r  <= 1'b0;
			rate_r       <= 3'h1;
			last_unit_r  <= 1'b0;
			test_en_r    <= 1'b0;
			lock_en_r    <= 1'b0;
			prolong_r    <= 1'b0;
			frame_r      <= 2'h0;
		end else if (cfg_load_r) begin
			cfg_load_r   <= 1'b0;
			role_basic_r <= unit_role_select_i;
			host_other_r <= host_family_select_i;
			flash_ext_r  <= flash_src_sel_i;
			rate_r       <= clk_rate_sel_i;
			last_unit_r  <= last_unit_sel_i;
			test_en_r    <= test_jmp_i;
			lock_en_r    <= lock_jmp_i;
			prolong_r    <= ~delay_off_i;
			frame_r      <= frame_addr_jmp_i;
		end
	end

	assign basic_unit_o     = role_basic_r;
	assign extension_unit_o = ~role_basic_r;
	assign host_other_o     = ~role_basic_r & host_other_r;
	assign slot_addr_bits_o = frame_r;
	assign slot_base        = slot_base_of(frame_r);
	assign slot_hit_o       = ~role_basic_r & (io_slot_i >= slot_base) &
		(io_slot_i <= slot_base + rbc_pkg::SLOT_SPAN);

	// Configuration error when not exactly one rate jumper
	assign cfg_err_o = (rate_r != 3'b001) && (rate_r != 3'b010) && (rate_r != 3'b100);

	// Control-logic tick at the selected rate
	assign div_val = div_of(rate_r);
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt_r <= 4'h0;
		end else if (div_cnt_r >= div_val - 4'h1) begin
			div_cnt_r <= 4'h0;
		end else begin
			div_cnt_r <= div_cnt_r + 4'h1;
		end
	end
	assign tick       = (div_cnt_r >= div_val - 4'h1);
	assign ctl_tick_o = tick;

	// Flash source
	rbc_flash u_flash (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.flash_o   (flash_int)
	);
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			err_flash_o <= 1'b0;
		end else begin
			err_flash_o <= flash_ext_r ? external_flash_line_i : flash_int;
		end
	end

	// Ready termination for the last unit
	assign periph_ready_input_o    = 1'b0;
	assign periph_ready_input_oe_o = ~role_basic_r & host_other_r & last_unit_r;

	// Access inhibit
	assign inhibit = (test_en_r & test_line_i) | (lock_en_r & lock_line_i);

	// Access cycle
	assign strobe_len = prolong_r ? rbc_pkg::STROBE_PROLONG : rbc_pkg::STROBE_NORMAL;
	assign cyc_lim    = prolong_r ? rbc_pkg::CYC_PROLONG_CNT : rbc_pkg::CYC_NORMAL_CNT;
	assign ack_both   = periph_ready_line_i & io_acknowledge_line_i;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			rbc_pkg::ST_IDLE: begin
				if (io_req_i && !inhibit && !cfg_err_o) begin
					state_nxt = rbc_pkg::ST_STROBE;
				end
			end
			rbc_pkg::ST_STROBE: begin
				if (tick && ph_cnt_r >= strobe_len - 8'h01) begin
					state_nxt = rbc_pkg::ST_WAIT;
				end
			end
			rbc_pkg::ST_WAIT: begin
				if (ack_both || cyc_cnt_r >= cyc_lim - 10'h001) begin
					state_nxt = rbc_pkg::ST_DONE;
				end
			end
			rbc_pkg::ST_DONE: begin
				state_nxt = rbc_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = rbc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= rbc_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ph_cnt_r <= 8'h00;
		end else if (state_r != rbc_pkg::ST_STROBE) begin
			ph_cnt_r <= 8'h00;
		end else if (tick) begin
			ph_cnt_r <= ph_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cyc_cnt_r <= 10'h000;
		end else if (state_r == rbc_pkg::ST_IDLE) begin
			cyc_cnt_r <= 10'h000;
		end else if (cyc_cnt_r != 10'h3FF) begin
			cyc_cnt_r <= cyc_cnt_r + 10'h001;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			io_done_o    <= 1'b0;
			io_timeout_o <= 1'b0;
			dbl_addr_o   <= 1'b0;
		end else begin
			io_done_o    <= done_ev;
			io_timeout_o <= tmo_ev;
			dbl_addr_o   <= dbl_ev;
		end
	end

	assign io_strobe_o = (state_r == rbc_pkg::ST_STROBE);
	assign io_busy_o   = (state_r != rbc_pkg::ST_IDLE);
	assign done_ev     = (state_r == rbc_pkg::ST_WAIT) && ack_both;
	assign tmo_ev      = (state_r == rbc_pkg::ST_WAIT) && !ack_both &&
		(cyc_cnt_r >= cyc_lim - 10'h001);
	// Two answering units pull acknowledge while ready disagrees
	assign dbl_ev = (state_r == rbc_pkg::ST_WAIT) && ~role_basic_r &&
		io_acknowledge_line_i && !periph_ready_line_i && slot_hit_o;
	assign blk_ev = (state_r == rbc_pkg::ST_IDLE) && io_req_i && inhibit;

	// Interrupt status, set wins over clear
	always_comb begin
		irq_set = 4'h0;
		irq_set[rbc_pkg::IRQ_DONE_BIT] = done_ev;
		irq_set[rbc_pkg::IRQ_DBL_BIT]  = dbl_ev;
		irq_set[rbc_pkg::IRQ_TMO_BIT]  = tmo_ev;
		irq_set[rbc_pkg::IRQ_BLK_BIT]  = blk_ev;
	end
	assign irq_clr = (reg_wr_i && reg_addr_i == rbc_pkg::ADDR_IRQ_CLR) ? reg_wdata_i[3:0] : 4'h0;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			irq_stat_r <= 4'h0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			irq_en_r <= rbc_pkg::IRQ_EN_RST;
		end else if (reg_wr_i && reg_addr_i == rbc_pkg::ADDR_IRQ_EN) begin
			irq_en_r <= reg_wdata_i[3:0];
		end
	end

	assign irq_o = |(irq_stat_r & irq_en_r);

	// Register read
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				rbc_pkg::ADDR_CFG:      reg_rdata_o <= {20'h0, frame_r, prolong_r, lock_en_r,
					test_en_r, last_unit_r, rate_r, flash_ext_r, host_other_r, role_basic_r};
				rbc_pkg::ADDR_STATUS:   reg_rdata_o <= {28'h0, state_r};
				rbc_pkg::ADDR_IRQ_STAT: reg_rdata_o <= {28'h0, irq_stat_r};
				rbc_pkg::ADDR_IRQ_EN:   reg_rdata_o <= {28'h0, irq_en_r};
				rbc_pkg::ADDR_CFG_ERR:  reg_rdata_o <= {31'h0, cfg_err_o};
				default:                reg_rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// file: testbench/rbc_partner.sv
// Far side of the remote bus: answers access cycles of the card
// Assumes the card's busy and strobe outputs on clk_sys_i
`timescale 1ns/10ps
`default_nettype none
module rbc_partner (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       io_busy_i,
	input  wire logic       io_strobe_i,
	input  wire logic [1:0] mode_i,
	output logic            ack_o,
	output logic            ready_o
);
	logic [3:0] wait_cnt_r;
	// Lines pulled inactive while nothing answers
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wait_cnt_r <= 4'h0;
			ack_o <= 1'b0;
			ready_o <= 1'b0;
		end else if (!io_busy_i || io_strobe_i) begin
			wait_cnt_r <= 4'h0;
			ack_o <= 1'b0;
			ready_o <= 1'b0;
		end else if (wait_cnt_r == 4'h3) begin
			ack_o <= (mode_i != 2'h0);
			ready_o <= (mode_i == 2'h1);
		end else begin
			wait_cnt_r <= wait_cnt_r + 4'h1;
		end
	end
endmodule
`default_nettype wire

// file: testbench/rbc_core_assertions.sv
// Port checker for the configuration control block
// Assumes one clock domain, bound onto rbc_core
`timescale 1ns/10ps
`default_nettype none
module rbc_chk (
	input wire logic       clk_sys_i,
	input wire logic       rst_i,
	input wire logic       unit_role_select_i,
	input wire logic [2:0] clk_rate_sel_i,
	input wire logic       test_jmp_i,
	input wire logic       test_line_i,
	input wire logic       lock_jmp_i,
	input wire logic       lock_line_i,
	input wire logic [5:0] io_slot_i,
	input wire logic       ctl_tick_o,
	input wire logic       io_busy_o,
	input wire logic       dbl_addr_o,
	input wire logic       slot_hit_o,
	input wire logic       periph_ready_input_o,
	input wire logic       periph_ready_input_oe_o,
	input wire logic       extension_unit_o,
	input wire logic       basic_unit_o,
	input wire logic       host_other_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	AST_ROLE: assert property (!$past(rst_i) |-> extension_unit_o != basic_unit_o)
		else $error("Role outputs disagree");
	AST_LOAD: assert property ($past(rst_i)
		|=> basic_unit_o == $past(unit_role_select_i))
		else $error("Role not taken from jumper");
	AST_HOST: assert property (host_other_o |-> extension_unit_o)
		else $error("Host family set in basic role");
	AST_TICK: assert property ($rose(ctl_tick_o) && clk_rate_sel_i == 3'h1
		|=> !ctl_tick_o [*3] ##1 ctl_tick_o)
		else $error("Slow tick period wrong");
	AST_FORCE: assert property (periph_ready_input_oe_o
		|-> extension_unit_o && host_other_o && !periph_ready_input_o)
		else $error("Ready forced in wrong role");
	AST_TEST: assert property (test_jmp_i && test_line_i && !io_busy_o |=> !io_busy_o)
		else $error("Access despite test inhibit");
	AST_LOCK: assert property (lock_jmp_i && lock_line_i && !io_busy_o |=> !io_busy_o)
		else $error("Access despite lock");
	AST_DBL: assert property (dbl_addr_o |-> extension_unit_o)
		else $error("Double address flagged in basic role");
	AST_CYC: assert property ($rose(io_busy_o) |-> ##[1:400] !io_busy_o)
		else $error("Access cycle too long");
	AST_SLOT: assert property (slot_hit_o |-> extension_unit_o && io_slot_i[3:0] <= 4'hD)
		else $error("Slot hit outside range");
	AST_STATIC: assert property (!$past(rst_i, 2) && !$past(rst_i)
		|-> $stable(extension_unit_o) && $stable(host_other_o))
		else $error("Configuration changed without reset");
endmodule
bind rbc_core rbc_chk u_rbc_chk (.clk_sys_i, .rst_i, .clk_rate_sel_i, .test_jmp_i, .test_line_i,
	.lock_jmp_i, .lock_line_i, .io_slot_i, .ctl_tick_o, .io_busy_o, .dbl_addr_o, .slot_hit_o,
	.periph_ready_input_o, .periph_ready_input_oe_o, .extension_unit_o, .basic_unit_o,
	.host_other_o, .unit_role_select_i);
`default_nettype wire

// file: testbench/test_remote_bus_interface_config.sv
// Self-checking bench for the configuration control block
// Assumes rbc_core, rbc_partner and the bound checker
`timescale 1ns/10ps
`default_nettype none
module test_remote_bus_interface_config;
	typedef struct packed {
		logic role, host, last;
		logic [2:0] rate;
		logic [1:0] frame;
		logic ext, oth, oe, err;
		logic [4:0] tk;
	} rbc_row_type;
	localparam rbc_row_type ROWS [6] = '{
		'{1'b0, 1'b0, 1'b0, 3'h4, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 5'h10},
		'{1'b0, 1'b1, 1'b1, 3'h2, 2'h1, 1'b1, 1'b1, 1'b1, 1'b0, 5'h08},
		'{1'b0, 1'b1, 1'b0, 3'h1, 2'h2, 1'b1, 1'b1, 1'b0, 1'b0, 5'h04},
		'{1'b1, 1'b1, 1'b1, 3'h4, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h10},
		'{1'b0, 1'b0, 1'b1, 3'h3, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 5'h04},
		'{1'b0, 1'b0, 1'b0, 3'h0, 2'h3, 1'b1, 1'b0, 1'b0, 1'b1, 5'h04}};
	logic clk_sys_i, rst_i, unit_role_select_i, host_family_select_i, flash_src_sel_i;
	logic last_unit_sel_i, test_jmp_i, lock_jmp_i, delay_off_i, external_flash_line_i;
	logic test_line_i, lock_line_i, io_req_i, periph_ready_line_i, io_acknowledge_line_i;
	logic reg_wr_i, reg_rd_i, irq_o, ctl_tick_o, io_strobe_o, io_busy_o, io_done_o, io_timeout_o;
	logic dbl_addr_o, slot_hit_o, periph_ready_input_o, periph_ready_input_oe_o, err_flash_o;
	logic extension_unit_o, basic_unit_o, host_other_o, cfg_err_o, bz;
	logic [2:0]  clk_rate_sel_i, f;
	logic [1:0]  frame_addr_jmp_i, p_mode, slot_addr_bits_o;
	logic [5:0]  io_slot_i;
	logic [3:0]  reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, v;
	int          err_count, compares, cycles, tk, n, ex, strobes;
	rbc_core u_rbc_core (.clk_sys_i, .rst_i, .unit_role_select_i, .host_family_select_i,
		.flash_src_sel_i, .clk_rate_sel_i, .last_unit_sel_i, .test_jmp_i, .lock_jmp_i,
		.delay_off_i, .frame_addr_jmp_i, .external_flash_line_i, .test_line_i, .lock_line_i,
		.io_req_i, .io_slot_i, .periph_ready_line_i, .io_acknowledge_line_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .ctl_tick_o, .io_strobe_o,
		.io_busy_o, .io_done_o, .io_timeout_o, .dbl_addr_o, .slot_hit_o, .periph_ready_input_o,
		.periph_ready_input_oe_o, .err_flash_o, .extension_unit_o, .basic_unit_o,
		.host_other_o, .slot_addr_bits_o, .cfg_err_o);
	rbc_partner u_rbc_partner (.clk_sys_i, .rst_i, .io_busy_i(io_busy_o),
		.io_strobe_i(io_strobe_o), .mode_i(p_mode), .ack_o(io_acknowledge_line_i),
		.ready_o(periph_ready_line_i));
	task automatic wrap_up;
		if (err_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	task automatic cy(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic rs;
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		cy(3);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		cy(0);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		cy(0);
		d = reg_rdata_o;
	endtask
	task automatic acc(output int cnt, output logic [2:0] fl);
		cnt = 0;
		fl = 3'h0;
		@(posedge clk_sys_i);
		io_req_i <= 1'b1;
		for (int i = 0; i < 8 && io_busy_o !== 1'b1; i++) cy(1);
		@(posedge clk_sys_i);
		io_req_i <= 1'b0;
		while (cnt < 500 && fl[1:0] == 2'h0) begin
			cy(1);
			cnt++;
			fl = fl | {dbl_addr_o, io_timeout_o, io_done_o};
		end
		cy(4);
	endtask
	always @(posedge clk_sys_i) begin
		cycles++;
		strobes += int'(io_strobe_o === 1'b1);
		if (cycles == 6000) begin
			err_count++;
			wrap_up();
		end
	end
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		{unit_role_select_i, host_family_select_i, flash_src_sel_i, last_unit_sel_i, test_jmp_i,
			lock_jmp_i, external_flash_line_i, test_line_i, lock_line_i, io_req_i, reg_wr_i,
			reg_rd_i, clk_rate_sel_i, frame_addr_jmp_i, p_mode, io_slot_i, reg_addr_i} = '0;
		{rst_i, delay_off_i, reg_wdata_i} = {2'h3, 32'h0000_0000};
		rs();
		foreach (ROWS[r]) begin
			@(posedge clk_sys_i);
			{unit_role_select_i, host_family_select_i, last_unit_sel_i} <= ROWS[r][16:14];
			clk_rate_sel_i <= ROWS[r].rate;
			frame_addr_jmp_i <= ROWS[r].frame;
			rs();
			chk("extension", 32'(ROWS[r].ext), 32'(extension_unit_o));
			chk("basic", 32'(!ROWS[r].ext), 32'(basic_unit_o));
			chk("host_other", 32'(ROWS[r].oth), 32'(host_other_o));
			chk("ready_force", 32'(ROWS[r].oe), 32'(periph_ready_input_oe_o));
			chk("cfg_err", 32'(ROWS[r].err), 32'(cfg_err_o));
			chk("slot_bits", 32'(ROWS[r].frame), 32'(slot_addr_bits_o));
			chk("ready_low", 32'h0000_0000, 32'(periph_ready_input_o));
			tk = 0;
			for (int k = -1; k < 15; k++) begin
				@(posedge clk_sys_i);
				io_slot_i <= {~ROWS[r].frame, 4'h0} + 6'(k);
				cy(0);
				tk += int'(ctl_tick_o === 1'b1);
				chk("slot_hit", 32'(ROWS[r].ext && k >= 0 && k < 14), 32'(slot_hit_o));
			end
			chk("ticks", 32'(ROWS[r].tk), 32'(tk));
		end
		for (int d = 1; d >= 0; d--) begin
			@(posedge clk_sys_i);
			{unit_role_select_i, host_family_select_i, last_unit_sel_i} <= 3'h0;
			{clk_rate_sel_i, frame_addr_jmp_i, io_slot_i} <= {3'h4, 2'h3, 6'h05};
			delay_off_i <= d[0];
			rs();
			ex = d ? int'(rbc_pkg::CYC_NORMAL_CNT) : int'(rbc_pkg::CYC_PROLONG_CNT);
			p_mode <= 2'h1;
			tk = strobes;
			acc(n, f);
			chk("strobe", 32'(d ? rbc_pkg::STROBE_NORMAL : rbc_pkg::STROBE_PROLONG),
				32'(strobes - tk));
			chk("done", 32'h0000_0001, 32'(f));
			p_mode <= 2'h0;
			acc(n, f);
			chk("timeout", 32'h0000_0002, 32'(f));
			chk("tmo_len", 32'h0000_0001, 32'(n + 8 > ex && n < ex + 4));
			p_mode <= 2'h2;
			acc(n, f);
			chk("double", 32'h0000_0001, 32'(f[2]));
		end
		rd(rbc_pkg::ADDR_IRQ_STAT, v);
		chk("irq_stat", 32'h0000_0007, v);
		wr(rbc_pkg::ADDR_IRQ_EN, 32'h0000_0001);
		chk("irq_on", 32'h0000_0001, 32'(irq_o));
		wr(rbc_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
		chk("irq_off", 32'h0000_0000, 32'(irq_o));
		rd(4'hF, v);
		chk("unmapped", 32'h0000_0000, v);
		@(posedge clk_sys_i);
		unit_role_select_i <= 1'b1;
		cy(3);
		chk("static_role", 32'h0000_0001, 32'(extension_unit_o));
		for (int j = 0; j < 2; j++) begin
			@(posedge clk_sys_i);
			{unit_role_select_i, test_jmp_i, lock_jmp_i} <= {1'b0, j == 0, j == 1};
			rs();
			@(posedge clk_sys_i);
			{test_line_i, lock_line_i, io_req_i} <= 3'h7;
			bz = 1'b0;
			repeat (20) begin
				cy(1);
				bz = bz | (io_busy_o !== 1'b0);
			end
			@(posedge clk_sys_i);
			{test_line_i, lock_line_i, io_req_i} <= 3'h0;
			chk("inhibit", 32'h0000_0000, 32'(bz));
			rd(rbc_pkg::ADDR_IRQ_STAT, v);
			chk("blocked", 32'h0000_0008, v);
		end
		@(posedge clk_sys_i);
		{flash_src_sel_i, test_jmp_i, lock_jmp_i} <= 3'h4;
		rs();
		for (int e = 0; e < 4; e++) begin
			@(posedge clk_sys_i);
			external_flash_line_i <= e[0];
			cy(3);
			chk("flash_ext", 32'(e[0]), 32'(err_flash_o));
		end
		@(posedge clk_sys_i);
		flash_src_sel_i <= 1'b0;
		rs();
		chk("flash_int", 32'h0000_0000, 32'(err_flash_o));
		wrap_up();
	end
endmodule
`default_nettype wire
